// >>> rtl/adc_serial_audio_port.sv
// Serial audio output port: control registers, frame and slot engine.
// Assumes samples arrive on clock with a one-cycle valid; the bit clock
// and frame clock pins are sampled on link_clk, which must run at least
// four times as fast as the bit clock; the testbench resolves the pins.
//
// How it works
// - Frame clock is 50% duty or one-bit pulse; polarity picks first half.
// - Data changes on falling bit-clock edge at 0, rising edge at 1.
// - Bit 4 enables reference, bit 5 regulator; both reset on.
// - Bits 3..0 enable channels one to four; all reset enabled.
// - Format 00 is I2S: first bit one bit clock after frame edge.
// - Format 01 left-justified, 10 right-justified 24, 11 right 16.
// - Layout 000 stereo, 001..100 TDM with 2, 4, 8, 16 slots.
// - TDM4 and up: select bit routes frame to primary or secondary.
// - TDM slot is 32, 24 or 16 bit clocks; code 11 reserved.
// - I2S and left-justified word is 24 bits at width bit 0, 16 bits at 1.
// - Words go MSB first at order 0, LSB first at 1.
// - Stereo master makes 32 or 16 bit clocks per channel by rate bit.
// - Master bit 0: both clocks are inputs; 1: device drives both.
// - Absent slots are not driven; lowest channel wins a shared slot.
`timescale 1ns/100ps
module adc_serial_audio_port (
  // System side
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clk,
  // Register port
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Converter side
  input wire logic sample_valid,
  input wire adc_serial_audio_pkg::sample_set_t sample_in,
  input wire logic [3:0][3:0] channel_slot_map,
  output logic [3:0] channel_enable,
  output logic reference_enable,
  output logic regulator_enable,
  // Link pins
  input wire logic bit_clock_in,
  output logic bit_clock_out,
  output logic bit_clock_oe,
  input wire logic frame_clock_in,
  output logic frame_clock_out,
  output logic frame_clock_oe,
  output logic serial_out_primary,
  output logic serial_out_primary_oe,
  output logic serial_out_secondary,
  output logic serial_out_secondary_oe
);
  typedef enum logic [2:0] {
    ST_LEAD = 3'b001, ST_RUN = 3'b010, ST_IDLE = 3'b100
  } frame_state_t;

  logic [7:0] power_ctrl, format_ctrl, frame_ctrl;
  adc_serial_audio_pkg::sample_set_t hold;
  logic samp_tog;

  // Register file
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_ctrl <= adc_serial_audio_pkg::RST_POWER;
      format_ctrl <= adc_serial_audio_pkg::RST_FORMAT;
      frame_ctrl <= adc_serial_audio_pkg::RST_FRAME;
    end else if (reg_write) begin
      if (reg_addr == adc_serial_audio_pkg::ADDR_POWER)
        power_ctrl <= reg_wdata;
      if (reg_addr == adc_serial_audio_pkg::ADDR_FORMAT)
        format_ctrl <= reg_wdata;
      if (reg_addr == adc_serial_audio_pkg::ADDR_FRAME)
        frame_ctrl <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        adc_serial_audio_pkg::ADDR_POWER: reg_rdata <= power_ctrl;
        adc_serial_audio_pkg::ADDR_FORMAT: reg_rdata <= format_ctrl;
        adc_serial_audio_pkg::ADDR_FRAME: reg_rdata <= frame_ctrl;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  assign channel_enable = power_ctrl[3:0];
  assign reference_enable =
    power_ctrl[adc_serial_audio_pkg::POS_REFERENCE];
  assign regulator_enable =
    power_ctrl[adc_serial_audio_pkg::POS_REGULATOR];

  // Hold the latest sample set; toggle announces it to the link side
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold <= '0;
      samp_tog <= 1'b0;
    end else if (sample_valid) begin
      hold <= sample_in;
      samp_tog <= ~samp_tog;
    end
  end

  adc_serial_audio_pkg::link_cfg_t cfg_raw, cfg_s1, cfg_s2, cfg_s3, cfg;
  always_comb begin
    cfg_raw.frame_clock_polarity =
      power_ctrl[adc_serial_audio_pkg::POS_POLARITY];
    cfg_raw.data_change_edge = power_ctrl[adc_serial_audio_pkg::POS_EDGE];
    cfg_raw.frame_clock_shape = frame_ctrl[adc_serial_audio_pkg::POS_SHAPE];
    cfg_raw.bit_order = frame_ctrl[adc_serial_audio_pkg::POS_ORDER];
    cfg_raw.master_bits_per_channel =
      frame_ctrl[adc_serial_audio_pkg::POS_BPC];
    cfg_raw.clock_master_select = frame_ctrl[adc_serial_audio_pkg::POS_MASTER];
    cfg_raw.output_pin_select = frame_ctrl[adc_serial_audio_pkg::POS_PIN_SEL];
    cfg_raw.width16 = frame_ctrl[adc_serial_audio_pkg::POS_WIDTH16];
    cfg_raw.framing_format =
      format_ctrl[adc_serial_audio_pkg::POS_FORMAT +: 2];
    cfg_raw.port_layout_mode =
      format_ctrl[adc_serial_audio_pkg::POS_LAYOUT +: 3];
    cfg_raw.slot_width = frame_ctrl[adc_serial_audio_pkg::POS_SLOT_W +: 2];
    cfg_raw.channel_enable = power_ctrl[3:0];
    cfg_raw.channel_slot_map = channel_slot_map;
  end

  // Link reset: asserts at once, releases on link_clk
  logic rl1, rst_link;
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      rl1 <= 1'b1;
      rst_link <= 1'b1;
    end else begin
      rl1 <= 1'b0;
      rst_link <= rl1;
    end
  end

  // Config is quasi-static; accept it only when two samples agree
  logic t1, t2, t3;
  always_ff @(posedge link_clk or posedge rst_link) begin
    if (rst_link) begin
      cfg_s1 <= '0;
      cfg_s2 <= '0;
      cfg_s3 <= '0;
      cfg <= '0;
      t1 <= 1'b0;
      t2 <= 1'b0;
      t3 <= 1'b0;
    end else begin
      cfg_s1 <= cfg_raw;
      cfg_s2 <= cfg_s1;
      cfg_s3 <= cfg_s2;
      if (cfg_s2 == cfg_s3)
        cfg <= cfg_s3;
      t1 <= samp_tog;
      t2 <= t1;
      t3 <= t2;
    end
  end

  // Pin inputs: three flops, change counts when second and third agree
  logic [2:0] bp, fp;
  logic bclk_f, lrclk_f;
  always_ff @(posedge link_clk or posedge rst_link) begin
    if (rst_link) begin
      bp <= 3'h0;
      fp <= 3'h0;
      bclk_f <= 1'b0;
      lrclk_f <= 1'b0;
    end else begin
      bp <= {bp[1:0], bit_clock_in};
      fp <= {fp[1:0], frame_clock_in};
      if (bp[1] == bp[2])
        bclk_f <= bp[2];
      if (fp[1] == fp[2])
        lrclk_f <= fp[2];
    end
  end

  function automatic logic [5:0] slot_bits(
    input adc_serial_audio_pkg::link_cfg_t c
  );
    if (c.port_layout_mode == adc_serial_audio_pkg::LAY_STEREO)
      slot_bits = c.master_bits_per_channel ? adc_serial_audio_pkg::BITS_16
        : adc_serial_audio_pkg::BITS_32;
    else if (c.slot_width == 2'h1)
      slot_bits = adc_serial_audio_pkg::BITS_24;
    else if (c.slot_width == 2'h2)
      slot_bits = adc_serial_audio_pkg::BITS_16;
    else
      slot_bits = adc_serial_audio_pkg::BITS_32;
  endfunction

  function automatic logic [4:0] slot_count(
    input adc_serial_audio_pkg::link_cfg_t c
  );
    if (c.port_layout_mode == adc_serial_audio_pkg::LAY_STEREO ||
        c.port_layout_mode > adc_serial_audio_pkg::LAY_TDM16)
      slot_count = 5'h02;
    else
      slot_count = 5'(5'h01 << c.port_layout_mode);
  endfunction

  // Lowest enabled channel mapped to slot wins; absent slots stay empty
  function automatic logic [2:0] owner(
    input adc_serial_audio_pkg::link_cfg_t c,
    input logic [4:0] slot
  );
    logic [4:0] limit;
    limit = (c.port_layout_mode == adc_serial_audio_pkg::LAY_STEREO)
      ? 5'h04 : slot_count(c);
    owner = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (c.channel_enable[i] && c.channel_slot_map[i] == slot[3:0] &&
          slot < limit)
        owner = {1'b1, 2'(i)};
    end
  endfunction

  // Bit clock source and edge events
  logic mdiv, bclk_prev, lr_samp, pend_edge, shift;
  logic bclk_lvl;
  assign bclk_lvl = cfg.clock_master_select ? mdiv : bclk_f;
  assign shift = cfg.data_change_edge ? (bclk_lvl & ~bclk_prev)
    : (~bclk_lvl & bclk_prev);

  always_ff @(posedge link_clk or posedge rst_link) begin
    if (rst_link) begin
      mdiv <= 1'b0;
      bclk_prev <= 1'b0;
    end else begin
      mdiv <= cfg.clock_master_select ? ~mdiv : 1'b0;
      bclk_prev <= bclk_lvl;
    end
  end

  // Slave frame edge judged at the data edge that carries it, so the
  // first bit leaves with the frame; limitation: the frame clock must not
  // reach its synchroniser later than the bit clock does
  assign pend_edge = lrclk_f == cfg.frame_clock_polarity &&
    lr_samp != cfg.frame_clock_polarity;
  always_ff @(posedge link_clk or posedge rst_link) begin
    if (rst_link) begin
      lr_samp <= 1'b0;
    end else if (shift) begin
      lr_samp <= lrclk_f;
    end
  end

  // Frame engine
  frame_state_t state, next_state;
  logic [9:0] fpos, next_fpos, flen, lr_len;
  logic [5:0] bis, next_bis, sw;
  logic [4:0] slot, next_slot, ns;
  logic start, i2s;
  adc_serial_audio_pkg::sample_set_t frame_buf;
  logic seen;

  assign sw = slot_bits(cfg);
  assign ns = slot_count(cfg);
  assign flen = 10'(ns) * 10'(sw);
  assign lr_len = cfg.frame_clock_shape ? 10'h001 : 10'(flen >> 1);
  assign i2s = cfg.framing_format == adc_serial_audio_pkg::FMT_I2S;
  assign start = cfg.clock_master_select ? (fpos == flen - 10'h001)
    : pend_edge;

  always_comb begin
    next_fpos = start ? 10'h000 : fpos + 10'h001;
    next_state = state;
    next_bis = bis;
    next_slot = slot;
    if (start) begin
      next_state = i2s ? ST_LEAD : ST_RUN;
      next_bis = 6'h00;
      next_slot = 5'h00;
    end else begin
      unique case (state)
        ST_LEAD: next_state = ST_RUN;
        ST_RUN: begin
          if (bis == sw - 6'h01) begin
            next_bis = 6'h00;
            next_slot = slot + 5'h01;
            if (slot == ns - 5'h01)
              next_state = ST_IDLE;
          end else begin
            next_bis = bis + 6'h01;
          end
        end
        ST_IDLE: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge rst_link) begin
    if (rst_link) begin
      state <= ST_IDLE;
      fpos <= 10'h000;
      bis <= 6'h00;
      slot <= 5'h00;
    end else if (shift) begin
      state <= next_state;
      fpos <= (fpos == 10'h3FF) ? fpos : next_fpos;
      bis <= next_bis;
      slot <= next_slot;
    end
  end

  // Take new samples only at frame start so a frame never mixes sets
  always_ff @(posedge link_clk or posedge rst_link) begin
    if (rst_link) begin
      frame_buf <= '0;
      seen <= 1'b0;
    end else if (shift && start && t3 != seen) begin
      frame_buf <= hold;
      seen <= t3;
    end
  end

  // Bit selection for the position being started
  function automatic adc_serial_audio_pkg::pin_drive_t pick(
    input adc_serial_audio_pkg::link_cfg_t c,
    input adc_serial_audio_pkg::sample_set_t s,
    input logic [2:0] own,
    input logic [5:0] b,
    input logic [5:0] width
  );
    logic [5:0] wlen, first, k, idx;
    logic rj;
    rj = c.framing_format[1];
    if (c.framing_format == adc_serial_audio_pkg::FMT_RJ16)
      wlen = adc_serial_audio_pkg::BITS_16;
    else if (rj)
      wlen = adc_serial_audio_pkg::BITS_24;
    else
      wlen = c.width16 ? adc_serial_audio_pkg::BITS_16
        : adc_serial_audio_pkg::BITS_24;
    first = (rj && width > wlen) ? width - wlen : 6'h00;
    k = b - first;
    idx = c.bit_order ? adc_serial_audio_pkg::BITS_24 - wlen + k
      : adc_serial_audio_pkg::MSB_INDEX - k;
    pick.enable = own[2] && b >= first && k < wlen;
    pick.data = pick.enable ? s.word[own[1:0]][idx[4:0]] : 1'b0;
  endfunction

  adc_serial_audio_pkg::pin_drive_t drv_p, drv_s;
  logic tdm, to_second;
  logic [2:0] own_p, own_s;
  always_comb begin
    tdm = cfg.port_layout_mode != adc_serial_audio_pkg::LAY_STEREO;
    to_second = tdm && cfg.output_pin_select &&
      cfg.port_layout_mode >= adc_serial_audio_pkg::LAY_TDM4;
    own_p = owner(cfg, next_slot);
    own_s = tdm ? own_p : owner(cfg, next_slot + 5'h02);
    drv_p = pick(cfg, frame_buf, own_p, next_bis, sw);
    drv_s = pick(cfg, frame_buf, own_s, next_bis, sw);
    if (next_state != ST_RUN) begin
      drv_p.enable = 1'b0;
      drv_s.enable = 1'b0;
    end
    if (tdm && to_second)
      drv_p.enable = 1'b0;
    if (tdm && !to_second)
      drv_s.enable = 1'b0;
  end

  always_ff @(posedge link_clk or posedge rst_link) begin
    if (rst_link) begin
      serial_out_primary <= 1'b0;
      serial_out_primary_oe <= 1'b0;
      serial_out_secondary <= 1'b0;
      serial_out_secondary_oe <= 1'b0;
      frame_clock_out <= 1'b0;
    end else if (shift) begin
      serial_out_primary <= drv_p.data;
      serial_out_primary_oe <= drv_p.enable;
      serial_out_secondary <= drv_s.data;
      serial_out_secondary_oe <= drv_s.enable;
      frame_clock_out <= (next_fpos < lr_len) ? cfg.frame_clock_polarity
        : ~cfg.frame_clock_polarity;
    end
  end

  always_ff @(posedge link_clk or posedge rst_link) begin
    if (rst_link) begin
      bit_clock_out <= 1'b0;
      bit_clock_oe <= 1'b0;
      frame_clock_oe <= 1'b0;
    end else begin
      bit_clock_out <= mdiv;
      bit_clock_oe <= cfg.clock_master_select;
      frame_clock_oe <= cfg.clock_master_select;
    end
  end

  // Checks
  AST_POWER_WRITE: assert property (@(posedge clock) disable iff (rst)
    reg_write && reg_addr == adc_serial_audio_pkg::ADDR_POWER |=>
    channel_enable == $past(reg_wdata[3:0]) &&
    reference_enable == $past(reg_wdata[4]))
    else $error("power enables did not follow write");
  AST_EDGE_ONLY: assert property (@(posedge link_clk)
    disable iff (rst_link) $changed(serial_out_primary_oe) |-> $past(shift))
    else $error("primary enable moved off the data edge");
  AST_SLAVE_PINS: assert property (@(posedge link_clk)
    disable iff (rst_link) !cfg.clock_master_select [*2] |=>
    !bit_clock_oe && !frame_clock_oe)
    else $error("clock pins driven in slave mode");
  AST_FRAME_FIRST: assert property (@(posedge link_clk)
    disable iff (rst_link) shift && start |=>
    frame_clock_out == $past(cfg.frame_clock_polarity))
    else $error("frame clock wrong at frame start");
  AST_I2S_LEAD: assert property (@(posedge link_clk)
    disable iff (rst_link) shift && start && i2s |=> state == ST_LEAD &&
    !serial_out_primary_oe && !serial_out_secondary_oe)
    else $error("I2S lead bit was driven");
  AST_PIN_ROUTE: assert property (@(posedge link_clk)
    disable iff (rst_link) shift && to_second |=> !serial_out_primary_oe)
    else $error("primary pin driven while routed to secondary");
  AST_SLOT_WRAP: assert property (@(posedge link_clk)
    disable iff (rst_link) shift && !start && state == ST_RUN &&
    bis == sw - 6'h01 |=> bis == 6'h00 && slot == $past(slot) + 5'h01)
    else $error("slot did not end at its width");
  AST_SLAVE_ALIGN: assert property (@(posedge link_clk)
    disable iff (rst_link) shift && !cfg.clock_master_select && pend_edge
    |=> slot == 5'h00 && bis == 6'h00 && fpos == 10'h000)
    else $error("slave frame not realigned");
  AST_MASTER_LEN: assert property (@(posedge link_clk)
    disable iff (rst_link) shift && cfg.clock_master_select &&
    fpos == flen - 10'h001 |=> fpos == 10'h000)
    else $error("master frame length wrong");
  COV_TDM_SECOND: cover property (@(posedge link_clk)
    shift && to_second && drv_s.enable);
  COV_I2S_FRAME: cover property (@(posedge link_clk)
    shift && start && i2s && cfg.clock_master_select);
  COV_SLAVE_EDGE: cover property (@(posedge link_clk)
    shift && pend_edge && !cfg.clock_master_select);
endmodule

// >>> common/adc_serial_audio_pkg.sv
// Register map, field layout and carrier types of the serial audio port.
// Assumes byte-wide registers reached over a simple strobe port.
package adc_serial_audio_pkg;
  localparam logic [7:0] ADDR_POWER = 8'h04;
  localparam logic [7:0] ADDR_FORMAT = 8'h05;
  localparam logic [7:0] ADDR_FRAME = 8'h06;
  localparam logic [7:0] RST_POWER = 8'h3F;
  localparam logic [7:0] RST_FORMAT = 8'h02;
  localparam logic [7:0] RST_FRAME = 8'h00;
  // Power and edge register
  localparam int POS_POLARITY = 7;
  localparam int POS_EDGE = 6;
  localparam int POS_REGULATOR = 5;
  localparam int POS_REFERENCE = 4;
  // Format register
  localparam int POS_FORMAT = 6;
  localparam int POS_LAYOUT = 3;
  // Frame register
  localparam int POS_PIN_SEL = 7;
  localparam int POS_SLOT_W = 5;
  localparam int POS_WIDTH16 = 4;
  localparam int POS_SHAPE = 3;
  localparam int POS_ORDER = 2;
  localparam int POS_BPC = 1;
  localparam int POS_MASTER = 0;
  localparam logic [5:0] BITS_32 = 6'h20;
  localparam logic [5:0] BITS_24 = 6'h18;
  localparam logic [5:0] BITS_16 = 6'h10;
  localparam logic [5:0] MSB_INDEX = 6'h17;

  typedef enum logic [1:0] {
    FMT_I2S = 2'h0, FMT_LEFT = 2'h1, FMT_RJ24 = 2'h2, FMT_RJ16 = 2'h3
  } framing_format_t;
  typedef enum logic [2:0] {
    LAY_STEREO = 3'h0, LAY_TDM2 = 3'h1, LAY_TDM4 = 3'h2,
    LAY_TDM8 = 3'h3, LAY_TDM16 = 3'h4
  } port_layout_mode_t;

  typedef struct packed {
    logic frame_clock_polarity;
    logic data_change_edge;
    logic frame_clock_shape;
    logic bit_order;
    logic master_bits_per_channel;
    logic clock_master_select;
    logic output_pin_select;
    logic width16;
    logic [1:0] framing_format;
    logic [2:0] port_layout_mode;
    logic [1:0] slot_width;
    logic [3:0] channel_enable;
    logic [3:0][3:0] channel_slot_map;
  } link_cfg_t;

  typedef struct packed {
    logic [3:0][23:0] word;
  } sample_set_t;

  typedef struct packed {
    logic data;
    logic enable;
  } pin_drive_t;
endpackage

// >>> bench/audio_host_model.sv
// Host receiver model for the serial audio port.
// Assumes resolved pins; drives the clocks while the port is slave.
`timescale 1ns/100ps
module audio_host_model (
  // Link pins
  input wire logic bclk,
  input wire logic fclk,
  input wire logic [1:0] sd,
  input wire logic [1:0] sd_oe,
  // Settings
  input wire logic edge_sel,
  input wire logic pol,
  input wire logic run_master,
  input wire logic [7:0] half_frame,
  // Host clocks
  output logic bclk_drv,
  output logic fclk_drv
);
  // Rows: primary data, drive, secondary data, drive, frame clock
  logic [255:0] cur [5];
  logic [255:0] cap [5];
  logic [1:0] sd_q, oe_q;
  logic f_q, fprev;
  int idx, frames, last_n, cnt;
  // Latch what stood just before the edge, as a real receiver does
  assign #1 sd_q = sd;
  assign #1 oe_q = sd_oe;
  assign #1 f_q = fclk;
  initial begin
    idx = 0;
    frames = 0;
    last_n = 0;
    cnt = 0;
    fprev = 1'b0;
    bclk_drv = 1'b0;
    fclk_drv = 1'b0;
  end
  always @(bclk) begin
    if (bclk ^ edge_sel) begin
      if (f_q === pol && fprev !== pol) begin
        cap = cur;
        last_n = idx;
        idx = 0;
        frames++;
        foreach (cur[i]) cur[i] = '0;
      end
      fprev = f_q;
      if (idx < 256) begin
        cur[0][idx] = sd_q[0];
        cur[1][idx] = oe_q[0];
        cur[2][idx] = sd_q[1];
        cur[3][idx] = oe_q[1];
        cur[4][idx] = f_q;
        idx++;
      end
    end
  end
  // Slow clocks leave room for the port's input synchronisers
  always begin
    #120;
    if (run_master) begin
      bclk_drv = ~bclk_drv;
      if (bclk_drv == edge_sel) begin
        cnt = (cnt + 1) % (2 * half_frame);
        fclk_drv = (cnt < half_frame) ? pol : ~pol;
      end
    end else begin
      bclk_drv = 1'b0;
    end
  end
endmodule

// >>> bench/adc_serial_audio_port_test.sv
// Self-checking bench for the serial audio port.
// Assumes audio_host_model stands at the far side of the link pins.
`timescale 1ns/100ps
module adc_serial_audio_port_test;
  localparam logic [3:0][23:0] W = {24'h1248BC, 24'hF0E1D2,
    24'h3C5A96, 24'hA5C3F1};
  logic clock, rst, link_clk, reg_write, reg_read, sample_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pw, half;
  adc_serial_audio_pkg::sample_set_t sample_in;
  logic [3:0][3:0] map;
  logic [3:0] channel_enable;
  logic reference_enable, regulator_enable, run_m, host_b, host_f;
  logic bclk_o, bclk_oe, fclk_o, fclk_oe, bclk, fclk;
  logic [1:0] sd, sd_oe;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  assign bclk = bclk_oe ? bclk_o : host_b;
  assign fclk = fclk_oe ? fclk_o : host_f;
  adc_serial_audio_port u_dut (
    .clock(clock), .rst(rst), .link_clk(link_clk),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_in(sample_in),
    .channel_slot_map(map), .channel_enable(channel_enable),
    .reference_enable(reference_enable),
    .regulator_enable(regulator_enable),
    .bit_clock_in(bclk), .bit_clock_out(bclk_o), .bit_clock_oe(bclk_oe),
    .frame_clock_in(fclk), .frame_clock_out(fclk_o),
    .frame_clock_oe(fclk_oe),
    .serial_out_primary(sd[0]), .serial_out_primary_oe(sd_oe[0]),
    .serial_out_secondary(sd[1]), .serial_out_secondary_oe(sd_oe[1]));
  audio_host_model u_host (
    .bclk(bclk), .fclk(fclk), .sd(sd), .sd_oe(sd_oe),
    .edge_sel(pw[6]), .pol(pw[7]), .run_master(run_m),
    .half_frame(half), .bclk_drv(host_b), .fclk_drv(host_f));
  always #25 clock = ~clock;
  initial begin
    link_clk = 1'b0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end
  task automatic end_sim;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      end_sim;
    end
  end
  task automatic chk(input logic [255:0] got, exp_v, input string m);
    n_tests++;
    if (got !== exp_v) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // Bits of one word on one line; drv 0 expects the pin released
  task automatic chk_word(input int ln, at, n, input logic [23:0] w,
    input logic lsb, drv);
    logic e;
    for (int k = 0; k < n; k++) begin
      e = lsb ? w[24 - n + k] : w[23 - k];
      chk(u_host.cap[2 * ln + 1][at + k], drv, "pin drive");
      if (drv) chk(u_host.cap[2 * ln][at + k], e, "data bit");
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clock);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp_v);
    @(negedge clock);
    reg_read = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_read = 1'b0;
    @(negedge clock);
    chk(reg_rdata, exp_v, "register read");
  endtask
  // Config changes land mid-frame, so judge the second whole frame after them
  task automatic setup(input logic [7:0] p, f, r, input logic [15:0] m);
    int f0;
    pw = p;
    map = m;
    wr(8'h04, p);
    wr(8'h05, f);
    wr(8'h06, r);
    f0 = u_host.frames;
    repeat (9000) if (u_host.frames < f0 + 3) @(negedge clock);
  endtask
  task automatic t_regs;
    rd(8'h04, 8'h3F);
    rd(8'h05, 8'h02);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    chk({regulator_enable, reference_enable, channel_enable}, 6'h3F,
      "pwr");
    wr(8'h04, 8'h25);
    wr(8'h09, 8'hFF);
    rd(8'h04, 8'h25);
    chk({regulator_enable, reference_enable}, 2'h2, "ref off");
    chk(channel_enable, 4'h5, "channel enables");
    $display("register test done");
  endtask
  task automatic t_master;
    setup(8'h3F, 8'h42, 8'h01, 16'h3210);
    chk({bclk_oe, fclk_oe}, 2'h3, "master drive");
    chk(u_host.last_n, 64, "stereo length");
    chk(u_host.cap[4][63:0], {{32{1'b1}}, 32'h0}, "duty");
    chk_word(0, 0, 24, W[0], 1'b0, 1'b1);
    chk_word(0, 24, 8, W[0], 1'b0, 1'b0);
    chk_word(0, 32, 24, W[1], 1'b0, 1'b1);
    chk_word(1, 0, 24, W[2], 1'b0, 1'b1);
    chk_word(1, 32, 24, W[3], 1'b0, 1'b1);
    $display("master stereo test done");
  endtask
  task automatic t_i2s;
    setup(8'hFF, 8'h02, 8'h09, 16'h3210);
    chk(u_host.last_n, 64, "i2s length");
    chk(u_host.cap[4][1:0], 2'h1, "pulse");
    chk_word(0, 0, 1, W[0], 1'b0, 1'b0);
    chk_word(0, 1, 24, W[0], 1'b0, 1'b1);
    chk_word(0, 33, 24, W[1], 1'b0, 1'b1);
    $display("i2s pulse test done");
  endtask
  task automatic t_rj16;
    setup(8'h3F, 8'hC2, 8'h05, 16'h3210);
    chk_word(0, 0, 16, W[0], 1'b1, 1'b0);
    chk_word(0, 16, 16, W[0], 1'b1, 1'b1);
    chk_word(0, 48, 16, W[1], 1'b1, 1'b1);
    $display("right justified test done");
  endtask
  task automatic t_tdm4;
    setup(8'h3E, 8'h92, 8'hA1, 16'h5110);
    chk(u_host.last_n, 96, "tdm4 length");
    chk_word(1, 0, 24, W[0], 1'b0, 1'b0);
    chk_word(1, 24, 24, W[1], 1'b0, 1'b1);
    chk_word(1, 48, 48, W[0], 1'b0, 1'b0);
    chk_word(0, 0, 96, W[0], 1'b0, 1'b0);
    $display("tdm4 secondary test done");
  endtask
  task automatic len(input logic [7:0] f, r, input int n);
    setup(8'h3F, f, r, 16'h3210);
    chk(u_host.last_n, n, "frame length");
  endtask
  task automatic t_len;
    len(8'h42, 8'h03, 32);
    len(8'h4A, 8'h01, 64);
    len(8'h62, 8'h41, 256);
    len(8'h5A, 8'h21, 192);
    $display("frame length test done");
  endtask
  task automatic t_slave;
    half = 8'h40;
    run_m = 1'b1;
    setup(8'h3F, 8'h5A, 8'h50, 16'h2107);
    chk({bclk_oe, fclk_oe}, 2'h0, "slave drive");
    chk(u_host.last_n, 128, "slave length");
    chk_word(0, 112, 16, W[0], 1'b0, 1'b1);
    chk_word(0, 16, 16, W[2], 1'b0, 1'b1);
    chk_word(0, 48, 64, W[0], 1'b0, 1'b0);
    $display("slave tdm8 test done");
  endtask
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    sample_valid = 1'b0;
    sample_in = W;
    map = 16'h3210;
    pw = 8'h3F;
    half = 8'h40;
    run_m = 1'b0;
    repeat (2) @(negedge clock);
    chk({bclk_oe, fclk_oe}, 2'h0, "reset drive");
    chk(sd_oe, 2'h0, "reset data drive");
    rst = 1'b0;
    @(negedge clock);
    sample_valid = 1'b1;
    @(negedge clock);
    sample_valid = 1'b0;
    t_regs;
    t_master;
    t_i2s;
    t_rj16;
    t_tdm4;
    t_len;
    t_slave;
    end_sim;
  end
endmodule
